// *** verilog/tsib_bank.sv ***
// status registers, interrupt masks and interrupt output of the framer
// assumes detector levels and pulses synchronous to sys_clk, one request per strobe
`timescale 1ns/10ps
`include "tsib_defs.svh"

// Summary of operation
// - identity register gives decimal die revision low, fixed device identity high.
// - sync-loss bit stays high while framer is not synchronised.
// - carrier loss after 255, 2048 extended, or 192 consecutive zeros on rails.
// - all-ones condition while received; yellow condition in T1 only.
// - sync-regained event set on synchronisation, held until status read.
// - end events when carrier loss, all-ones, yellow (T1) conditions end.
// - four alarm conditions of first status interrupt on rising edge when masked on.
// - clear events and frame events interrupt when mask set; masks reset to zero.
// - remote alarm condition in E1 mode only while received.
// - distant multiframe alarm in E1 when slot-16 bit is one two multiframes running.
// - link-detected condition in E1 mode on link identification signal.
// - clock-lost conditions when receive or transmit clock idle one channel time.
// - shared alarm output high on transmit clock loss when so configured.
// - loop-up, loop-down, spare code conditions held in T1 while received.
// - second status register conditions interrupt on both edges when mask set.
// - align-frame events in E1 for receive and transmit frames.
// - crc multiframe event in E1 on boundaries, free-running 2ms when crc4 off.
// - receive and transmit multiframe events on their multiframe boundaries.
// - signalling all-zeros event in E1 when slot 16 zero whole multiframe.
// - signalling all-ones event in E1, also active in common-channel mode.
// - customer-installation AIS event in T1 mode when pattern detected.
// - alarm output select 0 drives sync loss, 1 drives transmit clock loss.
module tsib_bank #(
  parameter int unsigned CRC_FREE_CYC = `TSIB_CRC_MF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire tsib_pkg::tsib_req_s host_req,
  output logic [7:0] host_rdata,
  output logic irq,
  output logic alarm_out,
  input wire logic e1_mode,
  input wire logic crc4_enable,
  input wire logic ext_zero_threshold,
  input wire logic alarm_output_select,
  input wire logic rx_positive_rail_in,
  input wire logic rx_negative_rail_in,
  input wire logic rx_recovered_clock_in,
  input wire logic tx_line_clock,
  input wire tsib_pkg::tsib_cond_s framer_cond,
  input wire tsib_pkg::tsib_evt_s framer_evt
);

  // ********************************************************
  // register decode
  // ********************************************************
  wire hit_id = host_req.addr == `TSIB_OFS_CHIP_IDENTITY;
  wire hit_sa = host_req.addr == `TSIB_OFS_ALARM_STATUS_A;
  wire hit_ma = host_req.addr == `TSIB_OFS_ALARM_MASK_A;
  wire hit_sb = host_req.addr == `TSIB_OFS_ALARM_STATUS_B;
  wire hit_mb = host_req.addr == `TSIB_OFS_ALARM_MASK_B;
  wire hit_sc = host_req.addr == `TSIB_OFS_FRAME_EVENT_STATUS;
  wire hit_mc = host_req.addr == `TSIB_OFS_FRAME_EVENT_MASK;
  wire clr_a = host_req.rd & hit_sa;
  wire clr_b = host_req.rd & hit_sb;
  wire clr_c = host_req.rd & hit_sc;
  wire t1_mode = ~e1_mode;

  logic [7:0] alarm_status_a_reg;
  logic [7:0] alarm_status_a_next;
  logic [7:0] alarm_mask_a_reg;
  logic [7:0] alarm_status_b_reg;
  logic [7:0] alarm_status_b_next;
  logic [7:0] alarm_mask_b_reg;
  logic [7:0] frame_event_status_reg;
  logic [7:0] frame_event_status_next;
  logic [7:0] frame_event_mask_reg;
  logic [7:0] pend_a_reg;
  logic [7:0] pend_b_reg;
  logic [7:0] pend_c_reg;
  logic [7:0] host_rdata_reg;
  logic irq_reg;
  logic alarm_out_reg;

  // ********************************************************
  // clock-loss watchdogs, one per line clock
  // ********************************************************
  localparam logic [7:0] CHAN_CYC = 8'(`TSIB_CHAN_CYC);
  wire [1:0] clk_in = {tx_line_clock, rx_recovered_clock_in};
  logic [1:0] clk_prev_reg;
  logic [1:0] clk_lost_reg;
  logic [7:0] idle_cnt_reg [2];

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_clk_watch
      wire moved = clk_in[gc] ^ clk_prev_reg[gc];
      wire expired = idle_cnt_reg[gc] == CHAN_CYC;
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          idle_cnt_reg[gc] <= 8'h00;
          clk_lost_reg[gc] <= 1'b0;
        end else begin
          idle_cnt_reg[gc] <= moved ? 8'h00 : (expired ? idle_cnt_reg[gc] : idle_cnt_reg[gc] + 8'h01);
          clk_lost_reg[gc] <= ~moved & expired;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_prev_reg <= 2'h0;
    end else begin
      clk_prev_reg <= clk_in;
    end
  end

  wire rx_clock_lost = clk_lost_reg[0];
  wire tx_clock_lost = clk_lost_reg[1];

  // ********************************************************
  // carrier loss: zero run counted on each receive clock rise
  // ********************************************************
  // limitation: one mark ends the loss; the ones-density clear is left to the framer
  logic [11:0] zero_run_reg;
  logic framer_carrier_loss_reg;
  wire bit_stb = rx_recovered_clock_in & ~clk_prev_reg[0];
  wire rail_zero = ~rx_positive_rail_in & ~rx_negative_rail_in;
  wire [11:0] zero_limit = e1_mode ?
    (ext_zero_threshold ? 12'(`TSIB_ZERO_RUN_E1_EXT) : 12'(`TSIB_ZERO_RUN_E1)) :
    12'(`TSIB_ZERO_RUN_T1);
  wire run_full = zero_run_reg >= zero_limit;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_run_reg <= 12'h000;
      framer_carrier_loss_reg <= 1'b0;
    end else if (bit_stb) begin
      zero_run_reg <= rail_zero ? (run_full ? zero_run_reg : zero_run_reg + 12'h001) : 12'h000;
      framer_carrier_loss_reg <= rail_zero & (zero_run_reg + 12'h001 >= zero_limit);
    end
  end

  // ********************************************************
  // distant multiframe alarm and free crc multiframe tick
  // ********************************************************
  logic dmf_hist_reg;
  logic distant_mf_alarm_reg;
  logic [31:0] crc_free_cnt_reg;
  wire crc_free_tick = crc_free_cnt_reg == CRC_FREE_CYC - 1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dmf_hist_reg <= 1'b0;
      distant_mf_alarm_reg <= 1'b0;
    end else if (framer_evt.rx_mf) begin
      dmf_hist_reg <= framer_cond.dmf_bit;
      distant_mf_alarm_reg <= framer_cond.dmf_bit & dmf_hist_reg;
    end
  end

  // free counter keeps the crc event alive when crc4 framing is off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      crc_free_cnt_reg <= 32'h0000_0000;
    end else begin
      crc_free_cnt_reg <= crc_free_tick ? 32'h0000_0000 : crc_free_cnt_reg + 32'h0000_0001;
    end
  end

  // ********************************************************
  // condition and event vectors
  // ********************************************************
  // sync loss level
  wire rx_sync_loss = framer_cond.sync_loss;
  wire rx_unframed_ones = framer_cond.unframed_ones;
  wire rx_yellow_alarm = framer_cond.yellow & t1_mode;
  wire [3:0] cond_a = {rx_yellow_alarm, rx_unframed_ones, framer_carrier_loss_reg, rx_sync_loss};
  logic [3:0] cond_a_prev_reg;
  logic [7:0] cond_b_prev_reg;
  wire rx_sync_regained_event = cond_a_prev_reg[0] & ~rx_sync_loss;
  wire carrier_loss_end_event = cond_a_prev_reg[1] & ~framer_carrier_loss_reg;
  wire unframed_ones_end_event = cond_a_prev_reg[2] & ~rx_unframed_ones;
  wire yellow_end_event = cond_a_prev_reg[3] & ~rx_yellow_alarm;
  wire [3:0] end_a = {yellow_end_event, unframed_ones_end_event, carrier_loss_end_event,
    rx_sync_regained_event};

  wire rx_remote_alarm = framer_cond.remote_alarm & e1_mode;
  wire distant_mf_alarm = distant_mf_alarm_reg & e1_mode;
  wire v5_link_detected = framer_cond.v5_link & e1_mode;
  wire loop_up_seen = framer_cond.loop_up & t1_mode;
  wire loop_down_seen = framer_cond.loop_down & t1_mode;
  wire spare_code_seen = framer_cond.spare_code & t1_mode;
  wire [7:0] cond_b = {spare_code_seen, loop_down_seen, loop_up_seen, tx_clock_lost,
    rx_clock_lost, v5_link_detected, distant_mf_alarm, rx_remote_alarm};

  wire rx_align_frame_event = framer_evt.rx_align & e1_mode;
  wire tx_align_frame_event = framer_evt.tx_align & e1_mode;
  wire rx_crc_multiframe_event = e1_mode & (crc4_enable ? framer_evt.rx_crc_mf : crc_free_tick);
  wire rx_multiframe_event = framer_evt.rx_mf;
  wire tx_multiframe_event = framer_evt.tx_mf;
  wire sig_all_zeros_event = framer_evt.sig_zeros & e1_mode;
  wire sig_all_ones_event = framer_evt.sig_ones & e1_mode;
  wire rx_ais_ci_event = framer_evt.ais_ci & t1_mode;
  wire [7:0] evt_c = {rx_ais_ci_event, sig_all_ones_event, sig_all_zeros_event,
    tx_multiframe_event, tx_align_frame_event, rx_multiframe_event, rx_crc_multiframe_event,
    rx_align_frame_event};

  // ********************************************************
  // latched status; a set in the cycle of a read wins
  // ********************************************************
  assign alarm_status_a_next = {end_a, cond_a} | (alarm_status_a_reg & {8{~clr_a}});
  assign alarm_status_b_next = cond_b | (alarm_status_b_reg & {8{~clr_b}});
  assign frame_event_status_next = evt_c | (frame_event_status_reg & {8{~clr_c}});

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cond_a_prev_reg <= 4'h0;
      cond_b_prev_reg <= 8'h00;
      alarm_status_a_reg <= `TSIB_RST_STATUS;
      alarm_status_b_reg <= `TSIB_RST_STATUS;
      frame_event_status_reg <= `TSIB_RST_STATUS;
    end else begin
      cond_a_prev_reg <= cond_a;
      cond_b_prev_reg <= cond_b;
      alarm_status_a_reg <= alarm_status_a_next;
      alarm_status_b_reg <= alarm_status_b_next;
      frame_event_status_reg <= frame_event_status_next;
    end
  end

  // ********************************************************
  // masks
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_mask_a_reg <= `TSIB_RST_MASK;
      alarm_mask_b_reg <= `TSIB_RST_MASK;
      frame_event_mask_reg <= `TSIB_RST_MASK;
    end else if (host_req.wr) begin
      if (hit_ma) begin
        alarm_mask_a_reg <= host_req.wdata;
      end
      if (hit_mb) begin
        alarm_mask_b_reg <= host_req.wdata;
      end
      if (hit_mc) begin
        frame_event_mask_reg <= host_req.wdata;
      end
    end
  end

  // ********************************************************
  // pending interrupt sources, cleared by reading the status
  // ********************************************************
  wire [7:0] src_a = {end_a, cond_a & ~cond_a_prev_reg};
  wire [7:0] src_b = cond_b ^ cond_b_prev_reg;

  genvar gb;
  generate
    for (gb = 0; gb < 8; gb = gb + 1) begin : g_pend
      wire set_a = src_a[gb] & alarm_mask_a_reg[gb];
      wire set_b = src_b[gb] & alarm_mask_b_reg[gb];
      wire set_c = evt_c[gb] & frame_event_mask_reg[gb];
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pend_a_reg[gb] <= 1'b0;
          pend_b_reg[gb] <= 1'b0;
          pend_c_reg[gb] <= 1'b0;
        end else begin
          pend_a_reg[gb] <= set_a | (pend_a_reg[gb] & ~clr_a);
          pend_b_reg[gb] <= set_b | (pend_b_reg[gb] & ~clr_b);
          pend_c_reg[gb] <= set_c | (pend_c_reg[gb] & ~clr_c);
        end
      end
    end
  endgenerate

  // ********************************************************
  // read data, interrupt and alarm outputs
  // ********************************************************
  // identity fields
  wire [7:0] id_value = {`TSIB_ID_DEVICE, `TSIB_ID_REVISION};
  // unmapped offsets read as zero
  wire [7:0] rd_mux =
    hit_id ? id_value :
    hit_sa ? alarm_status_a_reg :
    hit_ma ? alarm_mask_a_reg :
    hit_sb ? alarm_status_b_reg :
    hit_mb ? alarm_mask_b_reg :
    hit_sc ? frame_event_status_reg :
    hit_mc ? frame_event_mask_reg : 8'h00;
  wire irq_next = (|pend_a_reg) | (|pend_b_reg) | (|pend_c_reg);
  wire alarm_next = alarm_output_select ? tx_clock_lost : rx_sync_loss;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      alarm_out_reg <= 1'b0;
    end else begin
      if (host_req.rd) begin
        host_rdata_reg <= rd_mux;
      end
      irq_reg <= irq_next;
      alarm_out_reg <= alarm_next;
    end
  end

  assign host_rdata = host_rdata_reg;
  assign irq = irq_reg;
  assign alarm_out = alarm_out_reg;

endmodule : tsib_bank

// *** verilog/tsib_defs.svh ***
// register offsets, field positions, reset values and timing counts of the status bank
// assumes inclusion by the bank module, the assertion module and the bench
`ifndef TSIB_DEFS_SVH
`define TSIB_DEFS_SVH

// ********************************************************
// register offsets on the parallel port
// ********************************************************
`define TSIB_OFS_CHIP_IDENTITY 8'h0F
`define TSIB_OFS_ALARM_STATUS_A 8'h18
`define TSIB_OFS_ALARM_MASK_A 8'h19
`define TSIB_OFS_ALARM_STATUS_B 8'h1A
`define TSIB_OFS_ALARM_MASK_B 8'h1B
`define TSIB_OFS_FRAME_EVENT_STATUS 8'h1C
`define TSIB_OFS_FRAME_EVENT_MASK 8'h1D

// ********************************************************
// identity fields and reset values
// ********************************************************
`define TSIB_ID_REV_LSB 0
`define TSIB_ID_DEV_LSB 4
// arbitrary device identity value
`define TSIB_ID_DEVICE 4'h6
// arbitrary die revision, decimal code
`define TSIB_ID_REVISION 4'h1
`define TSIB_RST_STATUS 8'h00
`define TSIB_RST_MASK 8'h00
`define TSIB_COND_EDGE_BITS 4

// ********************************************************
// timing
// ********************************************************
`define TSIB_CLK_PERIOD_NS 50
`define TSIB_CHAN_TIME_NS 3906
`define TSIB_CHAN_CYC (((`TSIB_CHAN_TIME_NS) + (`TSIB_CLK_PERIOD_NS) - 1) / (`TSIB_CLK_PERIOD_NS))
`define TSIB_CRC_MF_US 2000
`define TSIB_CRC_MF_CYC ((`TSIB_CRC_MF_US) * 1000 / (`TSIB_CLK_PERIOD_NS))
`define TSIB_ZERO_RUN_E1 255
`define TSIB_ZERO_RUN_E1_EXT 2048
`define TSIB_ZERO_RUN_T1 192

`endif

// *** verilog/tsib_pkg.sv ***
// types shared by the status bank and its surroundings
// assumes nothing beyond the constant header
package tsib_pkg;

  // ********************************************************
  // framer detector levels, all synchronous to sys_clk
  // ********************************************************
  typedef struct packed {
    logic sync_loss;
    logic unframed_ones;
    logic yellow;
    logic remote_alarm;
    logic v5_link;
    logic loop_up;
    logic loop_down;
    logic spare_code;
    logic dmf_bit;
  } tsib_cond_s;

  // ********************************************************
  // framer one-cycle timing and signalling pulses
  // ********************************************************
  typedef struct packed {
    logic rx_align;
    logic tx_align;
    logic rx_crc_mf;
    logic rx_mf;
    logic tx_mf;
    logic sig_zeros;
    logic sig_ones;
    logic ais_ci;
  } tsib_evt_s;

  // ********************************************************
  // parallel register port request
  // ********************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsib_req_s;

endpackage : tsib_pkg

// *** sim/tsib_bank_asserts.sv ***
// concurrent checks on the status bank ports, bound to every tsib_bank
// assumes one host strobe per request and detector inputs in the sys_clk domain
`timescale 1ns/10ps
`include "tsib_defs.svh"
module tsib_bank_asserts #(
  parameter int unsigned CRC_FREE_CYC = 40000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire tsib_pkg::tsib_req_s host_req,
  input wire logic [7:0] host_rdata,
  input wire logic irq,
  input wire logic alarm_out,
  input wire logic e1_mode,
  input wire logic alarm_output_select,
  input wire logic rx_recovered_clock_in,
  input wire logic tx_line_clock,
  input wire tsib_pkg::tsib_cond_s framer_cond
);
  // ****************************************
  // mask shadows and line clock idle counters
  // ****************************************
  logic [7:0] msk_a, msk_b, msk_c, rx_idle, tx_idle;
  logic rx_q, tx_q;
  wire logic [7:0] adr = host_req.addr;
  wire logic rd_mask = host_req.rd && (adr == 8'h19 || adr == 8'h1B || adr == 8'h1D);
  wire logic [7:0] msk_sel = (adr == 8'h19) ? msk_a : ((adr == 8'h1B) ? msk_b : msk_c);
  wire logic [7:0] msk_all = msk_a | msk_b | msk_c;
  always_ff @(posedge sys_clk) begin
    rx_q <= rx_recovered_clock_in;
    tx_q <= tx_line_clock;
    if (rst) begin
      msk_a <= 8'h00;
      msk_b <= 8'h00;
      msk_c <= 8'h00;
      rx_idle <= 8'h00;
      tx_idle <= 8'h00;
    end else begin
      if (host_req.wr && adr == 8'h19) msk_a <= host_req.wdata;
      if (host_req.wr && adr == 8'h1B) msk_b <= host_req.wdata;
      if (host_req.wr && adr == 8'h1D) msk_c <= host_req.wdata;
      // saturate so a long stop never wraps back to a short count
      rx_idle <= (rx_recovered_clock_in != rx_q) ? 8'h00 : rx_idle + {7'h00, rx_idle != 8'hFF};
      tx_idle <= (tx_line_clock != tx_q) ? 8'h00 : tx_idle + {7'h00, tx_idle != 8'hFF};
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_id_value: assert property (
    host_req.rd && adr == 8'h0F |=> host_rdata == {`TSIB_ID_DEVICE, `TSIB_ID_REVISION})
    else $error("identity read wrong");
  a_mask_readback: assert property (
    rd_mask |=> host_rdata == $past(msk_sel)) else $error("mask read wrong");
  a_sync_level: assert property (
    host_req.rd && adr == 8'h18 && !$past(rst) && $past(framer_cond.sync_loss)
    |=> host_rdata[0]) else $error("sync loss bit low");
  a_ones_level: assert property (
    host_req.rd && adr == 8'h18 && !$past(rst) && $past(framer_cond.unframed_ones)
    |=> host_rdata[2]) else $error("all ones bit low");
  a_alarm_route: assert property (
    !$past(rst) && !$past(alarm_output_select) |-> alarm_out == $past(framer_cond.sync_loss))
    else $error("alarm output not sync loss");
  a_txlost_out: assert property (
    alarm_output_select && $past(alarm_output_select) && tx_idle >= 8'h5A |-> alarm_out)
    else $error("alarm output low on tx clock loss");
  a_rxlost_bit: assert property (
    host_req.rd && adr == 8'h1A && rx_idle >= 8'h5A |=> host_rdata[3])
    else $error("rx clock loss bit low");
  a_irq_source: assert property (
    $rose(irq) |-> ($past(msk_all, 2) != 8'h00 || $past(msk_all) != 8'h00))
    else $error("irq raised with all masks clear");
  a_fall_irq: assert property (
    !e1_mode && $past(!e1_mode) && msk_b[5] && $past(msk_b[5]) && $fell(framer_cond.loop_up)
    |-> ##[1:3] irq) else $error("no irq on condition fall");
  c_irq_read: cover property (irq ##1 host_req.rd);
  c_tx_alarm: cover property (alarm_out && alarm_output_select);
  c_loop_fall: cover property ($fell(framer_cond.loop_up) && msk_b[5]);
endmodule : tsib_bank_asserts

bind tsib_bank tsib_bank_asserts #(.CRC_FREE_CYC(CRC_FREE_CYC)) tsib_bank_asserts_inst (
  .sys_clk(sys_clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata), .irq(irq),
  .alarm_out(alarm_out), .e1_mode(e1_mode), .alarm_output_select(alarm_output_select),
  .rx_recovered_clock_in(rx_recovered_clock_in), .tx_line_clock(tx_line_clock),
  .framer_cond(framer_cond));

// *** sim/tsib_host.sv ***
// host processor model on the parallel register port
// assumes callers issue one access at a time; read expectations are queued in exp_q
`timescale 1ns/10ps
module tsib_host (
  input wire logic sys_clk,
  output tsib_pkg::tsib_req_s host_req
);
  logic [7:0] exp_q[$];
  initial host_req = '0;
  // ****************************************
  // strobe held across one rising edge, then an idle cycle
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    // released fields show junk so a late sample cannot pass by luck
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge sys_clk);
    host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask : rd
endmodule : tsib_host

// *** sim/tsib_bank_test.sv ***
// self-checking bench for the status bank, host model on the register port
// assumes read data stands from the edge after the strobe until the next read
`timescale 1ns/10ps
`include "tsib_defs.svh"
module tsib_bank_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic e1_mode = 1'b0, crc4 = 1'b1, ext_thr = 1'b0, sel = 1'b0;
  logic rx_pos = 1'b0, rx_neg = 1'b0, rxc = 1'b0, txc = 1'b0;
  logic rx_run = 1'b1, tx_run = 1'b1, zeros = 1'b0, rd_seen = 1'b0;
  logic [7:0] host_rdata, v;
  logic irq, alarm_out;
  tsib_pkg::tsib_req_s host_req;
  tsib_pkg::tsib_cond_s cond = '0;
  tsib_pkg::tsib_evt_s evt = '0;
  int err_count = 0;
  int samples_checked = 0;
  always #25 sys_clk = ~sys_clk;
  tsib_bank #(.CRC_FREE_CYC(20)) tsib_bank_inst (.sys_clk(sys_clk), .rst(rst),
    .host_req(host_req), .host_rdata(host_rdata), .irq(irq), .alarm_out(alarm_out),
    .e1_mode(e1_mode), .crc4_enable(crc4), .ext_zero_threshold(ext_thr),
    .alarm_output_select(sel), .rx_positive_rail_in(rx_pos), .rx_negative_rail_in(rx_neg),
    .rx_recovered_clock_in(rxc), .tx_line_clock(txc), .framer_cond(cond), .framer_evt(evt));
  tsib_host tsib_host_inst (.sys_clk(sys_clk), .host_req(host_req));
  // ****************************************
  // line side: clocks and random rails, all off the sampling edge
  // ****************************************
  always @(negedge sys_clk) begin
    rxc <= rx_run ? ~rxc : rxc;
    txc <= tx_run ? ~txc : txc;
    rx_pos <= zeros ? 1'b0 : 1'($urandom);
    rx_neg <= zeros ? 1'b0 : 1'($urandom);
  end
  // ****************************************
  // result watcher and reporting
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic mf_pulse();
    @(negedge sys_clk);
    evt.rx_mf = 1'b1;
    @(negedge sys_clk);
    evt.rx_mf = 1'b0;
  endtask : mf_pulse
  always @(posedge sys_clk) rd_seen <= host_req.rd;
  always @(negedge sys_clk) begin
    if (rd_seen && tsib_host_inst.exp_q.size() != 0)
      check(host_rdata, tsib_host_inst.exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(60690));
    idle(3);
    rst = 1'b0;
    tsib_host_inst.rd(8'h0F, {`TSIB_ID_DEVICE, `TSIB_ID_REVISION});
    tsib_host_inst.wr(8'h0F, 8'h00);
    tsib_host_inst.rd(8'h0F, {`TSIB_ID_DEVICE, `TSIB_ID_REVISION});
    for (int i = 0; i < 6; i++) tsib_host_inst.rd(8'(8'h18 + i), 8'h00);
    tsib_host_inst.rd(8'h20, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      tsib_host_inst.wr(8'(8'h19 + 2 * i), v);
      tsib_host_inst.rd(8'(8'h19 + 2 * i), v);
      tsib_host_inst.wr(8'(8'h19 + 2 * i), 8'h00);
    end
    tsib_host_inst.wr(8'h18, 8'hFF);
    tsib_host_inst.rd(8'h18, 8'h00);
    $display("test registers done");
    tsib_host_inst.wr(8'h19, 8'h01);
    for (int m = 0; m < 2; m++) begin
      e1_mode = m[0];
      {cond.sync_loss, cond.unframed_ones, cond.yellow} = 3'h7;
      idle(4);
      check({7'h00, irq}, 8'h01);
      tsib_host_inst.rd(8'h18, m ? 8'h05 : 8'h0D);
      {cond.sync_loss, cond.unframed_ones, cond.yellow} = 3'h0;
      idle(3);
      tsib_host_inst.rd(8'h18, m ? 8'h55 : 8'hDD);
      tsib_host_inst.rd(8'h18, 8'h00);
      idle(3);
      check({7'h00, irq}, 8'h00);
    end
    $display("test alarm status done");
    e1_mode = 1'b0;
    zeros = 1'b1;
    idle(370);
    tsib_host_inst.rd(8'h18, 8'h00);
    idle(30);
    tsib_host_inst.rd(8'h18, 8'h02);
    zeros = 1'b0;
    idle(40);
    tsib_host_inst.rd(8'h18, 8'h22);
    tsib_host_inst.rd(8'h18, 8'h00);
    $display("test carrier loss done");
    tsib_host_inst.wr(8'h1B, 8'h20);
    for (int m = 0; m < 2; m++) begin
      e1_mode = m[0];
      cond = 9'h03F;
      mf_pulse();
      mf_pulse();
      idle(3);
      check({7'h00, irq}, {7'h00, ~m[0]});
      tsib_host_inst.rd(8'h1A, m ? 8'h07 : 8'hE0);
      cond = '0;
      mf_pulse();
      mf_pulse();
      idle(3);
      check({7'h00, irq}, {7'h00, ~m[0]});
      tsib_host_inst.rd(8'h1A, m ? 8'h07 : 8'hE0);
      tsib_host_inst.rd(8'h1A, 8'h00);
      tsib_host_inst.rd(8'h1C, 8'h04);
    end
    $display("test alarm status b done");
    sel = 1'b1;
    tx_run = 1'b0;
    idle(90);
    check({7'h00, alarm_out}, 8'h01);
    tx_run = 1'b1;
    rx_run = 1'b0;
    idle(90);
    tsib_host_inst.rd(8'h1A, 8'h18);
    rx_run = 1'b1;
    sel = 1'b0;
    idle(5);
    tsib_host_inst.rd(8'h1A, 8'h08);
    tsib_host_inst.rd(8'h1A, 8'h00);
    $display("test clock loss done");
    tsib_host_inst.wr(8'h1D, 8'hFF);
    for (int m = 0; m < 2; m++) begin
      e1_mode = m[0];
      evt = 8'hFF;
      @(negedge sys_clk);
      evt = 8'h00;
      idle(3);
      check({7'h00, irq}, 8'h01);
      tsib_host_inst.rd(8'h1C, m ? 8'h7F : 8'h94);
      tsib_host_inst.rd(8'h1C, 8'h00);
    end
    crc4 = 1'b0;
    idle(45);
    tsib_host_inst.rd(8'h1C, 8'h02);
    crc4 = 1'b1;
    idle(3);
    $display("test frame events done");
    summarize();
  end
endmodule : tsib_bank_test
